// file: src/bsm_pkg.sv
package bsm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address on the bus is four times the index
    localparam logic [11:0] BSM_IDX_CTRL   = 12'hf52;
    localparam logic [11:0] BSM_IDX_UPPER  = 12'hf53;
    localparam logic [11:0] BSM_IDX_LOWER  = 12'hf54;
    localparam logic [11:0] BSM_IDX_STATE  = 12'hf55;
    localparam logic [11:0] BSM_IDX_MODE   = 12'hf56;
    localparam int          BSM_ADDR_W     = 14;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and field positions
    localparam logic [7:0]  BSM_RELOAD_RST = 8'hff;
    localparam logic [7:0]  BSM_FLAGS_RST  = 8'h02;
    localparam int          BSM_ON_BIT     = 7;
    localparam int          BSM_TSEL_BIT   = 4;
    localparam int          BSM_RSEL_BIT   = 0;
    localparam int          BSM_F_VALID    = 7;
    localparam int          BSM_F_REPLY    = 6;
    localparam int          BSM_F_ADDR     = 5;
    localparam int          BSM_F_DATA     = 4;
    localparam int          BSM_F_TEN      = 3;
    localparam int          BSM_F_RSTART   = 2;
    localparam int          BSM_F_SCLDRV   = 1;
    localparam int          BSM_F_BUSY     = 0;

    ////////////////////////////////////////////////////////////////////////////
    // substates and counter terminal
    localparam logic [3:0]  BSM_SUB_MSB    = 4'h7;
    localparam logic [3:0]  BSM_SUB_LSB    = 4'h0;
    localparam logic [3:0]  BSM_SUB_ACK    = 4'h8;
    localparam logic [3:0]  BSM_SUB_NONE   = 4'h0;
    localparam logic [3:0]  BSM_SUB_RESTRT = 4'h1;
    localparam logic [15:0] BSM_CNT_TERM   = 16'h0001;

    typedef enum logic [3:0] {
        BSM_IDLE    = 4'h0,
        BSM_S_START = 4'h1,
        BSM_S_BYST  = 4'h2,
        BSM_S_WAIT  = 4'h3,
        BSM_M_STOP2 = 4'h4,
        BSM_M_START = 4'h5,
        BSM_M_STOP1 = 4'h6,
        BSM_M_WAIT  = 4'h7,
        BSM_S_TX    = 4'h8,
        BSM_S_RX    = 4'h9,
        BSM_S_ADR1  = 4'ha,
        BSM_S_ADR2  = 4'hb,
        BSM_M_TX    = 4'hc,
        BSM_M_RX    = 4'hd,
        BSM_M_ADR1  = 4'he,
        BSM_M_ADR2  = 4'hf
    } bsm_main_t;

endpackage

// file: src/bsm_baud_gen.sv
`timescale 1ns/1ps
module bsm_baud_gen
    import bsm_pkg::*;
#(
    parameter int W = 16
)(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // control
    input  wire logic         run,
    input  wire logic [W-1:0] reload_value,
    // live count and quarter-bit tick
    output logic      [W-1:0] count,
    output logic              tick
);

    ////////////////////////////////////////////////////////////////////////////
    // a zero reload wraps through all ones, so it lasts 2**W cycles
    logic [W-1:0] count_reg;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            count_reg <= '1;
        else if (!run)
            count_reg <= reload_value;
        else if (count_reg == W'(BSM_CNT_TERM))
            count_reg <= reload_value;
        else
            count_reg <= count_reg - W'(1);
    end

    assign count = count_reg;
    // combinational tick; one cycle in every reload cycles
    assign tick  = run && (count_reg == W'(BSM_CNT_TERM));

endmodule

// file: src/bsm_line_mon.sv
`timescale 1ns/1ps
module bsm_line_mon
    import bsm_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // bus pins, asynchronous
    input  wire logic scl_in,
    input  wire logic sda_in,
    // detected bus conditions
    output logic      start_det,
    output logic      stop_det,
    output logic      busy
);

    ////////////////////////////////////////////////////////////////////////////
    // index 0 is the clock line, index 1 the data line
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic [1:0] prev_reg;
    logic       busy_reg;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= 2'h3;
            sync_reg <= 2'h3;
            prev_reg <= 2'h3;
        end
        else
        begin
            meta_reg <= {sda_in, scl_in};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // data edge while the clock line stays high
    assign start_det = sync_reg[0] && prev_reg[0] && prev_reg[1] && !sync_reg[1];
    assign stop_det  = sync_reg[0] && prev_reg[0] && !prev_reg[1] && sync_reg[1];

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            busy_reg <= 1'b0;
        else if (start_det)
            busy_reg <= 1'b1;
        else if (stop_det)
            busy_reg <= 1'b0;
    end

    assign busy = busy_reg;

endmodule

// file: src/bsm_top.sv
// Operation
// - reload value is upper byte on bits 15..8 and lower byte on 7..0
// - bit rate is system clock over four times the reload value
// - a zero reload counts as 65536
// - with readback_select set, reload byte reads return live counter bytes
// - state register is read-only; readback_select picks machine state over flags
// - diagnostic read gives main_state on bits 7..4, sub_state on 3..0
// - normal read gives eight status flags; only clock_line_drive resets high
// - main_state 0, 1, 2 are idle, slave start and slave bystander
// - main_state 3 is slave waiting for stop or restart after not-acknowledge
// - main_state 5 start, 6 first stop phase, 4 second stop phase
// - master not-acknowledge enters state 7 until software asks stop or start
// - states 8 to b are slave transmit, receive, address one, address two
// - states c to f are master transmit, receive, address one, address two
// - in byte phases sub_state counts bits from 7 down to 0
// - sub_state 8 marks the acknowledge bit, nine substates per byte
// - states without substates always show sub_state 0
// - in state 5, sub_state 0 is fresh start, 1 is repeated start
// - readback_select is bit 0 of the mode register
// - disabled with timer select set, generator runs and pulses at count one
// - timer select is ignored while controller_on is set
`timescale 1ns/1ps
module bsm_top
    import bsm_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // avalon-mm slave
    input  wire logic [BSM_ADDR_W-1:0] address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    // bus pins
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    // byte engine events, same clock
    input  wire logic                  bit_strobe,
    input  wire logic                  reply_bit,
    input  wire logic                  addr_hit,
    input  wire logic                  read_dir,
    input  wire logic                  ten_bit_mode,
    input  wire logic                  start_req,
    input  wire logic                  stop_req,
    input  wire logic                  clock_drive,
    // timing and observation
    output logic                       quarter_tick,
    output logic                       timer_irq,
    output logic                       controller_on,
    output logic      [3:0]            main_state,
    output logic      [3:0]            sub_state
);

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, read data captured on the first edge
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        on_reg;
    logic        tsel_reg;
    logic        rsel_reg;
    logic [7:0]  upper_reg;
    logic [7:0]  lower_reg;
    logic [15:0] reload_value;
    logic [15:0] count;
    logic        run;
    logic        start_det;
    logic        stop_det;
    logic        busy;
    logic [7:0]  flags;
    logic [7:0]  rd_byte;
    logic        wr_go;

    function automatic logic hit(input logic [11:0] idx, input logic [BSM_ADDR_W-1:0] a);
        hit = (a[1:0] == 2'h0) && (a[BSM_ADDR_W-1:2] == idx);
    endfunction

    assign waitrequest = (read || write) && !ack_reg;
    assign wr_go       = write && ack_reg && byteenable[0];

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            ack_reg <= 1'b0;
        else
            ack_reg <= (read || write) && !ack_reg;
    end

    always_comb
    begin
        rd_byte = 8'h00;
        if (hit(BSM_IDX_CTRL, address))
            rd_byte = {on_reg, 2'h0, tsel_reg, 4'h0};
        else if (hit(BSM_IDX_UPPER, address))
            rd_byte = rsel_reg ? count[15:8] : upper_reg;
        else if (hit(BSM_IDX_LOWER, address))
            rd_byte = rsel_reg ? count[7:0] : lower_reg;
        else if (hit(BSM_IDX_STATE, address))
            rd_byte = rsel_reg ? {main_state, sub_state} : flags;
        else if (hit(BSM_IDX_MODE, address))
            rd_byte = {7'h00, rsel_reg};
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_reg <= 32'h0000_0000;
        else if (read && !ack_reg)
            rdata_reg <= {24'h00_0000, rd_byte};
    end

    assign readdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // software registers; the state register has no write path
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            upper_reg <= BSM_RELOAD_RST;
            lower_reg <= BSM_RELOAD_RST;
        end
        else if (wr_go && hit(BSM_IDX_UPPER, address))
            upper_reg <= writedata[7:0];
        else if (wr_go && hit(BSM_IDX_LOWER, address))
            lower_reg <= writedata[7:0];
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            on_reg   <= 1'b0;
            tsel_reg <= 1'b0;
        end
        else if (wr_go && hit(BSM_IDX_CTRL, address))
        begin
            on_reg   <= writedata[BSM_ON_BIT];
            tsel_reg <= writedata[BSM_TSEL_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rsel_reg <= 1'b0;
        else if (wr_go && hit(BSM_IDX_MODE, address))
            rsel_reg <= writedata[BSM_RSEL_BIT];
    end

    assign controller_on = on_reg;

    ////////////////////////////////////////////////////////////////////////////
    // baud generator; a timer only while the controller is off
    assign reload_value = {upper_reg, lower_reg};
    assign run          = on_reg || tsel_reg;

    bsm_baud_gen #(
        .W            (16)
    ) u_baud (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .run          (run),
        .reload_value (reload_value),
        .count        (count),
        .tick         (quarter_tick)
    );

    // pulse per period as an extra timer
    assign timer_irq = quarter_tick && !on_reg && tsel_reg;

    bsm_line_mon u_line (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .start_det (start_det),
        .stop_det  (stop_det),
        .busy      (busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // controller state machine
    bsm_main_t main_reg;
    bsm_main_t main_next;
    logic [3:0] sub_reg;
    logic [3:0] sub_next;
    logic       byte_end;

    assign byte_end = main_reg[3] && bit_strobe && (sub_reg == BSM_SUB_ACK);

    always_comb
    begin
        main_next = main_reg;
        sub_next  = sub_reg;
        case (main_reg)
            BSM_IDLE:
            begin
                if (start_det)
                    main_next = BSM_S_START;
                else if (start_req && !busy)
                    main_next = BSM_M_START;
                sub_next = BSM_SUB_NONE;
            end
            BSM_S_START:
            begin
                main_next = BSM_S_ADR1;
                sub_next  = BSM_SUB_MSB;
            end
            BSM_S_BYST, BSM_S_WAIT:
            begin
                // stays put, ignoring traffic, until the bus frees or restarts
                if (stop_det)
                    main_next = BSM_IDLE;
                else if (start_det)
                    main_next = BSM_S_START;
            end
            BSM_M_START:
            begin
                if (quarter_tick)
                begin
                    main_next = BSM_M_ADR1;
                    sub_next  = BSM_SUB_MSB;
                end
            end
            BSM_M_STOP1:
            begin
                if (quarter_tick)
                    main_next = BSM_M_STOP2;
            end
            BSM_M_STOP2:
            begin
                if (quarter_tick)
                    main_next = BSM_IDLE;
            end
            BSM_M_WAIT:
            begin
                if (stop_req)
                    main_next = BSM_M_STOP1;
                else if (start_req)
                begin
                    main_next = BSM_M_START;
                    sub_next  = BSM_SUB_RESTRT;
                end
            end
            BSM_S_TX, BSM_S_RX, BSM_S_ADR1, BSM_S_ADR2,
            BSM_M_TX, BSM_M_RX, BSM_M_ADR1, BSM_M_ADR2:
            begin
                if (!main_reg[2] && stop_det)
                begin
                    main_next = BSM_IDLE;
                    sub_next  = BSM_SUB_NONE;
                end
                else if (!main_reg[2] && start_det)
                begin
                    main_next = BSM_S_START;
                    sub_next  = BSM_SUB_NONE;
                end
                else if (bit_strobe && sub_reg == BSM_SUB_LSB)
                    sub_next = BSM_SUB_ACK;
                else if (bit_strobe && sub_reg != BSM_SUB_ACK)
                    sub_next = sub_reg - 4'h1;
                else if (byte_end)
                begin
                    sub_next = BSM_SUB_MSB;
                    case (main_reg)
                        BSM_S_ADR1, BSM_S_ADR2:
                        begin
                            if (!addr_hit)
                                main_next = BSM_S_BYST;
                            else if (main_reg == BSM_S_ADR1 && ten_bit_mode)
                                main_next = BSM_S_ADR2;
                            else
                                main_next = read_dir ? BSM_S_TX : BSM_S_RX;
                        end
                        BSM_S_TX, BSM_S_RX:
                        begin
                            if (reply_bit)
                                main_next = BSM_S_WAIT;
                        end
                        BSM_M_ADR1, BSM_M_ADR2:
                        begin
                            if (reply_bit)
                                main_next = BSM_M_WAIT;
                            else if (main_reg == BSM_M_ADR1 && ten_bit_mode)
                                main_next = BSM_M_ADR2;
                            else
                                main_next = read_dir ? BSM_M_RX : BSM_M_TX;
                        end
                        default:
                        begin
                            if (reply_bit)
                                main_next = BSM_M_WAIT;
                            else if (stop_req)
                                main_next = BSM_M_STOP1;
                            else if (start_req)
                                main_next = BSM_M_START;
                        end
                    endcase
                    if (!main_next[3])
                        sub_next = (main_next == BSM_M_START) ? BSM_SUB_RESTRT : BSM_SUB_NONE;
                end
            end
            default:
            begin
                main_next = BSM_IDLE;
                sub_next  = BSM_SUB_NONE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            main_reg <= BSM_IDLE;
            sub_reg  <= BSM_SUB_NONE;
        end
        else if (!on_reg)
        begin
            main_reg <= BSM_IDLE;
            sub_reg  <= BSM_SUB_NONE;
        end
        else
        begin
            main_reg <= main_next;
            sub_reg  <= sub_next;
        end
    end

    assign main_state = main_reg;
    assign sub_state  = sub_reg;

    ////////////////////////////////////////////////////////////////////////////
    // status flags for normal readback
    logic valid_reg;
    logic reply_reg;
    logic ten_reg;
    logic rstart_reg;
    logic scl_reg;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            valid_reg <= 1'b0;
            reply_reg <= 1'b0;
        end
        else if (byte_end)
        begin
            valid_reg <= 1'b1; // set wins over the clear below
            reply_reg <= reply_bit;
        end
        else if (bit_strobe && sub_reg == BSM_SUB_MSB)
            valid_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            ten_reg <= 1'b0;
        else if (byte_end && (main_reg == BSM_S_ADR1 || main_reg == BSM_M_ADR1))
            ten_reg <= ten_bit_mode;
        else if (main_reg == BSM_IDLE)
            ten_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rstart_reg <= 1'b0;
        else if ((start_det && busy) || (main_next == BSM_M_START && sub_next == BSM_SUB_RESTRT))
            rstart_reg <= 1'b1;
        else if (stop_det)
            rstart_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            scl_reg <= 1'b1;
        else
            scl_reg <= clock_drive;
    end

    assign flags = {valid_reg, reply_reg, main_reg[3] && main_reg[1],
                    main_reg[3] && !main_reg[1], ten_reg, rstart_reg, scl_reg, busy};

    ////////////////////////////////////////////////////////////////////////////
    // checks; a cycle count bounds the second stop phase, a long delay range would be unrolled
    logic [16:0] stop2_cyc_reg;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            stop2_cyc_reg <= 17'h0_0000;
        else if (main_reg == BSM_M_STOP2)
            stop2_cyc_reg <= stop2_cyc_reg + 17'h0_0001;
        else
            stop2_cyc_reg <= 17'h0_0000;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_reload_join: assert property (reload_value[15:8] == upper_reg && reload_value[7:0] == lower_reg)
        else $error("reload bytes joined in the wrong order");
    a_zero_reload: assert property (run && $rose(quarter_tick) && reload_value == 16'h0000 |=>
                                    count == 16'h0000)
        else $error("zero reload not loaded as full count");
    a_tick_term: assert property (quarter_tick |-> count == BSM_CNT_TERM)
        else $error("tick away from terminal count");
    a_count_down: assert property (run && count != BSM_CNT_TERM && $stable(run) |=>
                                   count == $past(count) - 16'h0001)
        else $error("counter did not step down by one");
    a_upper_live: assert property (read && !ack_reg && rsel_reg && hit(BSM_IDX_UPPER, address) |=>
                                   readdata[7:0] == $past(count[15:8]))
        else $error("upper byte readback not the live count");
    a_state_readback_select: assert property (read && !ack_reg && rsel_reg && hit(BSM_IDX_STATE, address) |=>
                                   readdata[7:4] == $past(main_state) && readdata[3:0] == $past(sub_state))
        else $error("diagnostic state readback wrong");
    a_state_flags: assert property (read && !ack_reg && !rsel_reg && hit(BSM_IDX_STATE, address) |=>
                                    readdata[7:0] == $past(flags) && readdata[31:8] == 24'h00_0000)
        else $error("normal state readback wrong");
    a_no_sub: assert property (!main_reg[3] && main_reg != BSM_M_START |-> sub_reg == BSM_SUB_NONE)
        else $error("substate seen in a state without substates");
    a_start_sub: assert property (main_reg == BSM_M_START |-> sub_reg <= BSM_SUB_RESTRT)
        else $error("start state substate out of range");
    a_ack_follows: assert property (on_reg && main_reg[3] && sub_reg == BSM_SUB_LSB && bit_strobe &&
                                    main_reg[2] |=> sub_reg == BSM_SUB_ACK)
        else $error("acknowledge substate missing after bit zero");
    a_wait_hold: assert property (main_reg == BSM_M_WAIT && on_reg && !start_req && !stop_req |=>
                                  main_reg == BSM_M_WAIT)
        else $error("master wait left without software request");
    a_stop_seq: assert property (main_reg == BSM_M_STOP1 && quarter_tick && on_reg |=>
                                 main_reg == BSM_M_STOP2)
        else $error("stop sequence broken");
    a_stop2_bound: assert property (main_reg == BSM_M_STOP2 |-> stop2_cyc_reg < 17'h1_0000)
        else $error("second stop phase outlived one generator period");
    a_timer_gate: assert property (timer_irq |-> !on_reg && tsel_reg && count == BSM_CNT_TERM)
        else $error("timer pulse while controller on");

    c_restart: cover property (main_reg == BSM_M_START && sub_reg == BSM_SUB_RESTRT);
    c_byte_done: cover property (byte_end && main_reg == BSM_M_TX);
    c_timer: cover property (timer_irq ##[1:300] timer_irq);
    c_bystander: cover property (main_reg == BSM_S_BYST);

endmodule

// file: verif/bsm_bus_peer.sv
`timescale 1ns/1ps
module bsm_bus_peer
(
    // system clock
    input  wire logic ref_clk,
    // bus lines, pulled up when released
    output logic      scl,
    output logic      sda
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // clock stays high: 0 gives a start, 1 a stop
    task automatic cond(input logic lvl);
        @(posedge ref_clk);
        sda <= lvl;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// file: verif/bsm_tb_top.sv
`timescale 1ns/1ps
module bsm_tb_top;
    import bsm_pkg::*;
    logic                  ref_clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
    logic [BSM_ADDR_W-1:0] address = '0;
    logic [31:0]           writedata = '0, readdata, r;
    logic [3:0]            main_state, sub_state;
    logic                  waitrequest, bit_strobe = 1'b0, start_req = 1'b0, reply_bit = 1'b0;
    logic                  scl, sda, quarter_tick, timer_irq, controller_on;
    logic [7:0]            q;
    logic [3:0]            be = 4'hf;
    logic                  stop_req = 1'b0, clock_drive = 1'b1;
    int                    n_mismatch = 0, checked = 0, cyc = 0, seed = 9, n;
    always #2.5 ref_clk = ~ref_clk;
    bsm_bus_peer u_bsm_bus_peer (.ref_clk(ref_clk), .scl(scl), .sda(sda));
    bsm_top u_bsm_top (.ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
        .scl_in(scl), .sda_in(sda), .bit_strobe(bit_strobe), .reply_bit(reply_bit), .addr_hit(1'b0),
        .read_dir(1'b0), .ten_bit_mode(1'b0), .start_req(start_req), .stop_req(stop_req),
        .clock_drive(clock_drive), .quarter_tick(quarter_tick), .timer_irq(timer_irq),
        .controller_on(controller_on), .main_state(main_state), .sub_state(sub_state));
    ////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
        address <= {idx, 2'b00};
        read <= !w;
        write <= w;
        writedata <= {24'h0, d};
        @(posedge ref_clk iff waitrequest === 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [3:0] sub_after(input int i);
        sub_after = (i == 8) ? BSM_SUB_ACK : 4'(7 - i);
    endfunction
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // bounded so a stuck state machine cannot hang the run
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        bus(0, BSM_IDX_UPPER, 0); chk(q, 8'hff);
        bus(0, BSM_IDX_LOWER, 0); chk(q, 8'hff);
        bus(1, BSM_IDX_STATE, 8'h5a);
        bus(0, BSM_IDX_STATE, 0); chk(q, 8'h02);
        bus(0, 12'h3ff, 0); chk(q, 8'h00);
        r = $random(seed);
        clock_drive <= r[16];
        bus(1, BSM_IDX_UPPER, r[15:8]);
        bus(1, BSM_IDX_LOWER, r[7:0]);
        be <= 4'h0;
        bus(1, BSM_IDX_UPPER, ~r[15:8]);
        be <= 4'hf;
        bus(0, BSM_IDX_UPPER, 0); chk(q, r[15:8]);
        bus(0, BSM_IDX_LOWER, 0); chk(q, r[7:0]);
        bus(0, BSM_IDX_STATE, 0); chk(q, {6'h00, r[16], 1'b0});
        bus(1, BSM_IDX_UPPER, 8'h02);
        bus(1, BSM_IDX_LOWER, 8'h00);
        bus(1, BSM_IDX_CTRL, 8'h10);
        bus(1, BSM_IDX_MODE, 8'h01);
        @(posedge ref_clk iff quarter_tick === 1'b1);
        chk({7'h0, timer_irq}, 8'h01);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (quarter_tick !== 1'b1);
        chk(8'(n >> 8), 8'h02);
        chk(8'(n), 8'h00);
        bus(0, BSM_IDX_UPPER, 0); chk(q, 8'h02);
        bus(1, BSM_IDX_CTRL, 8'h90);
        n = 0;
        repeat (600) @(posedge ref_clk) if (timer_irq !== 1'b0) n++;
        chk(8'(n), 8'h00);
        u_bsm_bus_peer.cond(1'b0);
        chk({main_state, sub_state}, 8'ha7);
        u_bsm_bus_peer.cond(1'b1);
        chk({main_state, sub_state}, 8'h00);
        start_req <= 1'b1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (main_state !== BSM_M_START && n < 50);
        start_req <= 1'b0;
        chk({main_state, sub_state}, 8'h50);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (main_state !== BSM_M_ADR1 && n < 600);
        chk({main_state, sub_state}, 8'he7);
        for (int i = 1; i <= 8; i++)
        begin
            bit_strobe <= 1'b1;
            @(posedge ref_clk);
            bit_strobe <= 1'b0;
            @(posedge ref_clk);
            chk({4'h0, sub_state}, {4'h0, sub_after(i)});
        end
        bus(0, BSM_IDX_STATE, 0); chk(q, 8'he8);
        reply_bit <= 1'b1;
        bit_strobe <= 1'b1;
        @(posedge ref_clk);
        bit_strobe <= 1'b0;
        @(posedge ref_clk);
        chk({main_state, sub_state}, 8'h70);
        stop_req <= 1'b1;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (main_state !== BSM_M_STOP2 && n < 1200);
        chk({main_state, sub_state}, 8'h40);
        do begin @(posedge ref_clk); n++; end while (main_state !== BSM_IDLE && n < 1200);
        stop_req <= 1'b0;
        chk({main_state, sub_state}, 8'h00);
        stop_test;
    end
endmodule
